// File: core/pin_function_select.sv
// Pin function selector for ports D, E, F and G with capture source routing
//
// Overview of operation
// - Port D pin 0: codes 00/01 GPIO plus ptimer2 capture, 10 ptimer2 out, 11 oscillator one.
// - Port D pin 1: codes 00/01 GPIO plus ptimer1 capture, 10 ptimer1 out, 11 oscillator two.
// - Port D pin 2 is always GPIO and ptimer1 external clock.
// - Port D pin 4 is always GPIO and ptimer2 external clock.
// - Port D pin 5: codes 00..10 GPIO plus ptimer0 capture, 11 ptimer0 output.
// - Port D pin 6: codes 00..10 GPIO plus ptimer2 capture, 11 ptimer2 output.
// - Port D pin 7: codes 00..10 GPIO plus ptimer1 capture, 11 ptimer1 output.
// - Port E pin 0: 00/01 GPIO, 10 I/O supply pin, 11 external reference.
// - Port E pin 3: 00..10 GPIO, 11 crystal terminal one.
// - Port E pin 4: 00..10 GPIO, 11 crystal terminal two.
// - Port E pin 2: 00..10 GPIO, 11 analog channel 17.
// - Port E pin 5: 00..10 GPIO, 11 analog channel 16.
// - Port E low select bits 3 and 2 are not stored and read zero.
// - Port E 6-7, port F 2-7, port G 0-2 are always plain GPIO.
// - Port F pins 0 and 1: 00..10 GPIO plus ptimer3 capture, 11 ptimer3 output.
// - Port G pin 3: 00..10 GPIO, 11 analog channel 23.
// - Port G pins 4..7: code 11 gives analog channels 22, 21, 20, 19.
// - Source bit 5 feeds ptimer4 capture from B7 (0) or C0 (1).
// - Source bit 4 feeds ptimer3 capture from F0 (0) or F1 (1).
// - Source bit 2 feeds ptimer1 capture from D7 (0) or D1 (1).
// - Source bit 1 feeds ptimer0 capture from A5 (0) or D5 (1).
// - Source bit 0 feeds standard timer capture from A4 (0) or B4 (1).
`include "pin_function_select_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pin_function_select #(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   // Register port
   input  wire logic [ADDR_W-1:0]            regAddr,
   input  wire logic [7:0]                   regWdata,
   input  wire logic                         regWe,
   input  wire logic                         regRe,
   output logic      [7:0]                   regRdata,
   // Pads
   input  wire pin_function_select_pkg::pin_bus_t  padIn,
   input  wire pin_function_select_pkg::aux_pins_t auxPadIn,
   output pin_function_select_pkg::pin_bus_t       padOut,
   output pin_function_select_pkg::pin_bus_t       padOe,
   output pin_function_select_pkg::pin_bus_t       padAnalog,
   // General purpose I/O block
   input  wire pin_function_select_pkg::pin_bus_t  gpioOut,
   input  wire pin_function_select_pkg::pin_bus_t  gpioOe,
   output pin_function_select_pkg::pin_bus_t       gpioIn,
   // Timers
   input  wire logic [3:0]                   ptimerOut,
   output pin_function_select_pkg::capture_in_t    captureIn,
   output logic                              ptimer1ExtClock,
   output logic                              ptimer2ExtClock,
   // Analog and clock functions
   output logic      [23:16]                 analogChanEn,
   output pin_function_select_pkg::special_fn_t    specialFn
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (ADDR_W < 4) begin : g_bad_addr
      $error("ADDR_W must be at least 4");
   end

   localparam int NPIN = 32;
   localparam int NRAW = 37;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]      selR [0:7];
   logic [7:0]      srcR;
   logic [7:0]      rdataR;
   logic [7:0]      rdMux;
   logic            addrInSel;
   logic            addrIsSrc;

   assign addrInSel = (regAddr < ADDR_W'(8));
   assign addrIsSrc = (regAddr == ADDR_W'(`OFF_CAPTURE_INPUT_SOURCE));

   genvar gi;
   for (gi = 0; gi < 8; gi++) begin : g_sel
      logic        hit;
      logic [7:0]  wmask;
      assign hit   = regWe && (regAddr == ADDR_W'(gi));
      assign wmask = (gi == `OFF_PORT_E_LOW_PIN_SELECT) ? `WMASK_PORT_E_LOW
                                                        : `WMASK_PIN_SELECT;
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            selR[gi] <= `RST_PIN_SELECT;
         end else if (hit) begin
            selR[gi] <= regWdata & wmask;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         srcR <= `RST_CAPTURE_INPUT_SOURCE;
      end else if (regWe && addrIsSrc) begin
         srcR <= regWdata & `WMASK_CAPTURE_SOURCE;
      end
   end

   // Read data only in the cycle after the strobe, zero elsewhere
   assign rdMux = addrInSel ? selR[regAddr[2:0]] : (addrIsSrc ? srcR : 8'h00);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdataR <= 8'h00;
      end else begin
         rdataR <= regRe ? rdMux : 8'h00;
      end
   end

   assign regRdata = rdataR;

   // ---------------------------------------------------------------
   // Pin input synchronisers
   // ---------------------------------------------------------------
   logic [NRAW-1:0] rawIn;
   logic [NRAW-1:0] syncOne;
   logic [NRAW-1:0] syncTwo;
   logic [NRAW-1:0] syncThree;
   logic [NRAW-1:0] filtR;
   logic [NPIN-1:0] pinV;
   pin_function_select_pkg::aux_pins_t auxV;

   assign rawIn = {auxPadIn, padIn};

   for (gi = 0; gi < NRAW; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            syncOne[gi]   <= 1'b0;
            syncTwo[gi]   <= 1'b0;
            syncThree[gi] <= 1'b0;
            filtR[gi]     <= 1'b0;
         end else begin
            syncOne[gi]   <= rawIn[gi];
            syncTwo[gi]   <= syncOne[gi];
            syncThree[gi] <= syncTwo[gi];
            if (syncTwo[gi] == syncThree[gi]) begin
               filtR[gi] <= syncThree[gi];
            end
         end
      end
   end

   assign pinV = filtR[NPIN-1:0];
   assign auxV = filtR[NRAW-1:NPIN];

   // ---------------------------------------------------------------
   // Per-pin function decode
   // ---------------------------------------------------------------
   function automatic logic [1:0] timerOf(input int n);
      case (n)
         0, 6:    timerOf = 2'd2;
         1, 7:    timerOf = 2'd1;
         16, 17:  timerOf = 2'd3;
         default: timerOf = 2'd0;
      endcase
   endfunction

   logic [1:0]      fieldCode [0:NPIN-1];
   logic [NPIN-1:0] timerSel;
   logic [NPIN-1:0] analogSel;
   logic [NPIN-1:0] captureOk;
   logic [NPIN-1:0] padOutNxt;
   logic [NPIN-1:0] padOeNxt;
   logic [NPIN-1:0] padOutR;
   logic [NPIN-1:0] padOeR;
   logic [NPIN-1:0] padAnalogR;
   logic [NPIN-1:0] gpioInR;
   logic [NPIN-1:0] gpioOutV;
   logic [NPIN-1:0] gpioOeV;

   assign gpioOutV = gpioOut;
   assign gpioOeV  = gpioOe;

   // Pins without entries in the maps stay plain GPIO
   for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic [31:0] bitSel;
      assign bitSel         = 32'h00000001 << gi;
      assign fieldCode[gi]  = selR[gi / 4][2 * (gi % 4) +: 2];
      assign timerSel[gi]   = ((fieldCode[gi] == `CODE_ALT_A) && |(bitSel & `MAP_TIMER_OUT_ALT_A))
                            | ((fieldCode[gi] == `CODE_ALT_B) && |(bitSel & `MAP_TIMER_OUT_ALT_B));
      assign analogSel[gi]  = ((fieldCode[gi] == `CODE_ALT_A) && |(bitSel & `MAP_ANALOG_ALT_A))
                            | ((fieldCode[gi] == `CODE_ALT_B) && |(bitSel & `MAP_ANALOG_ALT_B));
      assign captureOk[gi]  = ~(timerSel[gi] | analogSel[gi]);
      // Timer drives only when its field is selected
      assign padOutNxt[gi]  = timerSel[gi] ? ptimerOut[timerOf(gi)] : gpioOutV[gi];
      assign padOeNxt[gi]   = timerSel[gi] | (~analogSel[gi] & gpioOeV[gi]);

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            padOutR[gi]    <= 1'b0;
            padOeR[gi]     <= 1'b0;
            padAnalogR[gi] <= 1'b0;
            gpioInR[gi]    <= 1'b0;
         end else begin
            padOutR[gi]    <= padOutNxt[gi];
            padOeR[gi]     <= padOeNxt[gi];
            padAnalogR[gi] <= analogSel[gi];
            gpioInR[gi]    <= pinV[gi] & ~analogSel[gi];
         end
      end
   end

   assign padOut    = padOutR;
   assign padOe     = padOeR;
   assign padAnalog = padAnalogR;
   assign gpioIn    = gpioInR;

   // ---------------------------------------------------------------
   // Capture routing and external clocks
   // ---------------------------------------------------------------
   pin_function_select_pkg::capture_in_t captureNxt;
   pin_function_select_pkg::capture_in_t captureR;
   pin_function_select_pkg::special_fn_t specialNxt;
   pin_function_select_pkg::special_fn_t specialR;
   logic [23:16]    analogNxt;
   logic [23:16]    analogR;
   logic            extClk1R;
   logic            extClk2R;

   assign captureNxt.stimer  = srcR[`BIT_STIMER_SRC] ? auxV.b4 : auxV.a4;
   assign captureNxt.ptimer0 = srcR[`BIT_PTIMER0_SRC] ? (pinV[5] & captureOk[5]) : auxV.a5;
   assign captureNxt.ptimer1 = srcR[`BIT_PTIMER1_SRC] ? (pinV[1] & captureOk[1])
                                                      : (pinV[7] & captureOk[7]);
   assign captureNxt.ptimer2 = srcR[`BIT_PTIMER2_SRC] ? (pinV[0] & captureOk[0])
                                                      : (pinV[6] & captureOk[6]);
   assign captureNxt.ptimer3 = srcR[`BIT_PTIMER3_SRC] ? (pinV[17] & captureOk[17])
                                                      : (pinV[16] & captureOk[16]);
   assign captureNxt.ptimer4 = srcR[`BIT_PTIMER4_SRC] ? auxV.c0 : auxV.b7;

   assign specialNxt.oscOne     = (fieldCode[0] == `CODE_ALT_B);
   assign specialNxt.oscTwo     = (fieldCode[1] == `CODE_ALT_B);
   assign specialNxt.ioSupply   = (fieldCode[8] == `CODE_ALT_A);
   assign specialNxt.vref       = (fieldCode[8] == `CODE_ALT_B);
   assign specialNxt.crystalOne = (fieldCode[11] == `CODE_ALT_B);
   assign specialNxt.crystalTwo = (fieldCode[12] == `CODE_ALT_B);

   assign analogNxt[16] = (fieldCode[13] == `CODE_ALT_B);
   assign analogNxt[17] = (fieldCode[10] == `CODE_ALT_B);
   assign analogNxt[18] = 1'b0;
   assign analogNxt[19] = (fieldCode[31] == `CODE_ALT_B);
   assign analogNxt[20] = (fieldCode[30] == `CODE_ALT_B);
   assign analogNxt[21] = (fieldCode[29] == `CODE_ALT_B);
   assign analogNxt[22] = (fieldCode[28] == `CODE_ALT_B);
   assign analogNxt[23] = (fieldCode[27] == `CODE_ALT_B);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         captureR <= '0;
         specialR <= '0;
         analogR  <= 8'h00;
         extClk1R <= 1'b0;
         extClk2R <= 1'b0;
      end else begin
         captureR <= captureNxt;
         specialR <= specialNxt;
         analogR  <= analogNxt;
         extClk1R <= pinV[2];
         extClk2R <= pinV[4];
      end
   end

   assign captureIn       = captureR;
   assign specialFn       = specialR;
   assign analogChanEn    = analogR;
   assign ptimer1ExtClock = extClk1R;
   assign ptimer2ExtClock = extClk2R;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_pd0_timer_out: assert property (fieldCode[0] == 2'h2 |=> padOeR[0] && padOutR[0] == $past(ptimerOut[2]))
      else $error("port D pin 0 does not carry ptimer2 output");
   a_pd0_osc: assert property (fieldCode[0] == 2'h3 |=> specialR.oscOne && padAnalogR[0] && !padOeR[0])
      else $error("port D pin 0 not handed to oscillator one");
   a_pd1_select: assert property (fieldCode[1] == 2'h2 |=> padOeR[1] && padOutR[1] == $past(ptimerOut[1]))
      else $error("port D pin 1 does not carry ptimer1 output");
   a_pd1_osc: assert property (fieldCode[1] == 2'h3 |=> specialR.oscTwo && !padOeR[1])
      else $error("port D pin 1 not handed to oscillator two");
   a_pd2_ext_clock: assert property (pinV[2] ##1 pinV[2] |-> ptimer1ExtClock && padOeR[2] == $past(gpioOeV[2]))
      else $error("port D pin 2 left its fixed function");
   a_pd4_ext_clock: assert property (!pinV[4] ##1 !pinV[4] |-> !ptimer2ExtClock && padOutR[4] == $past(gpioOutV[4]))
      else $error("port D pin 4 left its fixed function");
   a_pd5_gpio_hold: assert property (fieldCode[5] != 2'h3 |=> padOeR[5] == $past(gpioOeV[5]))
      else $error("port D pin 5 driven while in GPIO mode");
   a_pd5_timer_out: assert property (fieldCode[5] == 2'h3 |=> padOeR[5] && padOutR[5] == $past(ptimerOut[0]))
      else $error("port D pin 5 does not carry ptimer0 output");
   a_pd6_timer_out: assert property (fieldCode[6] == 2'h3 |=> padOutR[6] == $past(ptimerOut[2]) && padOeR[6])
      else $error("port D pin 6 does not carry ptimer2 output");
   a_pd7_timer_out: assert property (fieldCode[7] == 2'h3 |=> padOutR[7] == $past(ptimerOut[1]) && padOeR[7])
      else $error("port D pin 7 does not carry ptimer1 output");
   a_pe0_supply_ref: assert property (fieldCode[8][1] |=> !padOeR[8] && (specialR.ioSupply ^ specialR.vref))
      else $error("port E pin 0 supply or reference selection wrong");
   a_pe3_crystal: assert property (fieldCode[11] == 2'h3 |=> specialR.crystalOne && padAnalogR[11])
      else $error("port E pin 3 not handed to crystal terminal one");
   a_pe4_crystal: assert property (fieldCode[12] != 2'h3 |=> !specialR.crystalTwo && !padAnalogR[12])
      else $error("port E pin 4 taken from GPIO early");
   a_pe2_analog: assert property (fieldCode[10] == 2'h3 |=> analogChanEn[17] && !padOeR[10])
      else $error("port E pin 2 not routed to analog channel 17");
   a_pe5_analog: assert property (fieldCode[13] == 2'h3 |=> analogChanEn[16] && padAnalogR[13])
      else $error("port E pin 5 not routed to analog channel 16");
   a_pe_low_reserved: assert property (regRe && regAddr == ADDR_W'(2) |=> regRdata[3:2] == 2'b00)
      else $error("port E low select reserved bits read non-zero");
   a_plain_gpio: assert property (1'b1 |=> ((padOeR ^ $past(gpioOeV)) & `MAP_PLAIN_GPIO) == 32'h0)
      else $error("plain GPIO pin diverted");
   a_pf_timer3_out: assert property (fieldCode[16] == 2'h3 |=> padOutR[16] == $past(ptimerOut[3]))
      else $error("port F pin 0 does not carry ptimer3 output");
   a_pg3_analog: assert property (fieldCode[27] == 2'h3 |=> analogChanEn[23] && padAnalogR[27])
      else $error("port G pin 3 not routed to analog channel 23");
   a_pg_high_analog: assert property (fieldCode[31] == 2'h3 && fieldCode[28] != 2'h3 |=> analogChanEn[19] && !analogChanEn[22])
      else $error("port G high analog channel mapping wrong");
   a_pt4_source: assert property (srcR[5] |=> captureIn.ptimer4 == $past(auxV.c0))
      else $error("ptimer4 capture source wrong");
   a_pt3_source: assert property (!srcR[4] && captureOk[16] |=> captureIn.ptimer3 == $past(pinV[16]))
      else $error("ptimer3 capture source wrong");
   a_pt1_source: assert property (srcR[2] && captureOk[1] |=> captureIn.ptimer1 == $past(pinV[1]))
      else $error("ptimer1 capture source wrong");
   a_pt0_source: assert property (!srcR[1] |=> captureIn.ptimer0 == $past(auxV.a5))
      else $error("ptimer0 capture source wrong");
   a_st_source: assert property (srcR[0] |=> captureIn.stimer == $past(auxV.b4))
      else $error("standard timer capture source wrong");
   a_pt2_source: assert property (srcR[3] && captureOk[0] |=> captureIn.ptimer2 == $past(pinV[0]))
      else $error("ptimer2 capture source wrong");
   a_reset_clear: assert property ($past(rst) |-> srcR == 8'h00 && selR[0] == 8'h00 && selR[7] == 8'h00)
      else $error("select registers not cleared by reset");
   a_src_top_zero: assert property (regRe && addrIsSrc |=> regRdata[7:6] == 2'b00)
      else $error("source register top bits read non-zero");

   c_timer_out: cover property (regWe && regAddr == ADDR_W'(0) && regWdata[1:0] == 2'h2 ##2 padOeR[0]);
   c_analog: cover property (fieldCode[28] == 2'h3 ##1 analogChanEn[22]);
   c_src_switch: cover property (regWe && addrIsSrc && regWdata[4] ##1 srcR[4]);
   c_read_back: cover property (regRe && addrInSel ##1 regRdata != 8'h00);

endmodule

`default_nettype wire

// File: core/pin_function_select_map.svh
// Register offsets, reset values, write masks and pin function maps
`ifndef PIN_FUNCTION_SELECT_MAP_SVH
`define PIN_FUNCTION_SELECT_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (one byte register per address)
// ---------------------------------------------------------------
`define OFF_PORT_D_LOW_PIN_SELECT   4'h0
`define OFF_PORT_D_HIGH_PIN_SELECT  4'h1
`define OFF_PORT_E_LOW_PIN_SELECT   4'h2
`define OFF_PORT_E_HIGH_PIN_SELECT  4'h3
`define OFF_PORT_F_LOW_PIN_SELECT   4'h4
`define OFF_PORT_F_HIGH_PIN_SELECT  4'h5
`define OFF_PORT_G_LOW_PIN_SELECT   4'h6
`define OFF_PORT_G_HIGH_PIN_SELECT  4'h7
`define OFF_CAPTURE_INPUT_SOURCE    4'h8

// ---------------------------------------------------------------
// Reset values and writable bits
// ---------------------------------------------------------------
`define RST_PIN_SELECT              8'h00
`define RST_CAPTURE_INPUT_SOURCE    8'h00
`define WMASK_PIN_SELECT            8'hFF
`define WMASK_PORT_E_LOW            8'hF3
`define WMASK_CAPTURE_SOURCE        8'h3F

// ---------------------------------------------------------------
// Source select bit positions
// ---------------------------------------------------------------
`define BIT_STIMER_SRC              0
`define BIT_PTIMER0_SRC             1
`define BIT_PTIMER1_SRC             2
`define BIT_PTIMER2_SRC             3
`define BIT_PTIMER3_SRC             4
`define BIT_PTIMER4_SRC             5

// ---------------------------------------------------------------
// Field codes and per-pin function maps (bit n = pin n, D..G)
// ---------------------------------------------------------------
`define CODE_ALT_A                  2'h2
`define CODE_ALT_B                  2'h3
`define MAP_TIMER_OUT_ALT_A         32'h00000003
`define MAP_TIMER_OUT_ALT_B         32'h000300E0
`define MAP_ANALOG_ALT_A            32'h00000100
`define MAP_ANALOG_ALT_B            32'hF8003D03
`define MAP_PLAIN_GPIO              32'h07FCC014

`endif

// File: core/pin_function_select_pkg.sv
// Types shared by the pin function selector
package pin_function_select_pkg;

   // Pins of ports D..G, port D in the low byte
   typedef struct packed {
      logic [7:0] g;
      logic [7:0] f;
      logic [7:0] e;
      logic [7:0] d;
   } pin_bus_t;

   // Capture-capable pins of ports A..C
   typedef struct packed {
      logic c0;
      logic b7;
      logic b4;
      logic a5;
      logic a4;
   } aux_pins_t;

   // Capture inputs delivered to the timers
   typedef struct packed {
      logic ptimer4;
      logic ptimer3;
      logic ptimer2;
      logic ptimer1;
      logic ptimer0;
      logic stimer;
   } capture_in_t;

   // Clock, supply and reference functions of the pins
   typedef struct packed {
      logic vref;
      logic ioSupply;
      logic crystalTwo;
      logic crystalOne;
      logic oscTwo;
      logic oscOne;
   } special_fn_t;

endpackage

// File: sim/pad_model.sv
// Board-side pad model for the pin function selector
`timescale 1ns/1ps
`default_nettype none

module pad_model (
   // Design side
   input  wire pin_function_select_pkg::pin_bus_t padOut,
   input  wire pin_function_select_pkg::pin_bus_t padOe,
   // Board side
   input  wire logic [31:0]                       extLevel,
   output pin_function_select_pkg::pin_bus_t      padIn
);
   // Driven pins show the driven level, released pins the board level
   assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule

`default_nettype wire

// File: sim/pin_function_select_tb_top.sv
// Self-checking testbench for the pin function selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errCount++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end

module pin_function_select_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                                clk_sys   = 1'b0;
   logic                                rst       = 1'b1;
   logic [3:0]                          regAddr   = 4'h0;
   logic [7:0]                          regWdata  = 8'h00;
   logic                                regWe     = 1'b0;
   logic                                regRe     = 1'b0;
   logic [7:0]                          regRdata;
   logic [31:0]                         extLevel  = 32'h0;
   logic [4:0]                          auxPadIn  = 5'h0;
   logic [31:0]                         gpioOut   = 32'h0;
   logic [31:0]                         gpioOe    = 32'h0;
   logic [3:0]                          ptimerOut = 4'h0;
   pin_function_select_pkg::pin_bus_t   padIn, padOut, padOe, padAnalog, gpioIn;
   pin_function_select_pkg::capture_in_t captureIn;
   pin_function_select_pkg::special_fn_t specialFn;
   logic                                ptimer1ExtClock, ptimer2ExtClock;
   logic [23:16]                        analogChanEn;
   int                                  errCount  = 0;
   int                                  checks    = 0;

   always #2.5 clk_sys = ~clk_sys;

   pin_function_select i_pin_function_select (.clk_sys, .rst, .regAddr, .regWdata, .regWe, .regRe, .regRdata,
      .padIn, .auxPadIn, .padOut, .padOe, .padAnalog, .gpioOut, .gpioOe, .gpioIn, .ptimerOut, .captureIn,
      .ptimer1ExtClock, .ptimer2ExtClock, .analogChanEn, .specialFn);
   pad_model i_pad_model (.padOut, .padOe, .extLevel, .padIn);

   // ----------------------------------------
   // Bus tasks and expectations
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWe    <= 1'b1;
      @(posedge clk_sys);
      regWe    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRe   <= 1'b1;
      @(posedge clk_sys);
      regRe   <= 1'b0;
      #1;
      `CHK(regRdata, e)
      @(posedge clk_sys);
      #1;
      `CHK(regRdata, 8'h00)
   endtask

   // Timer-output mask, timer values and analog mask when every field holds c
   function automatic void pins(input logic [1:0] c, input logic [3:0] p, output logic [31:0] tm,
                                output logic [31:0] tv, output logic [31:0] an);
      tm = 32'h0;
      tv = 32'h0;
      tm[1:0] = {2{c == 2'h2}};
      tv[1:0] = {p[1], p[2]};
      tm[7:5] = {3{c == 2'h3}};
      tv[7:5] = {p[1], p[2], p[0]};
      tm[17:16] = {2{c == 2'h3}};
      tv[17:16] = {2{p[3]}};
      an = {{5{c == 2'h3}}, 13'h0, {4{c == 2'h3}}, 1'b0, c[1], 6'h0, {2{c == 2'h3}}};
   endfunction

   // Capture inputs; x is {c0,b7,b4,a5,a4}
   function automatic logic [5:0] cap(input logic [5:0] s, input logic [31:0] p, input logic [4:0] x);
      return {s[5] ? x[4] : x[3], s[4] ? p[17] : p[16], s[3] ? p[0] : p[6], s[2] ? p[1] : p[7],
              s[1] ? p[5] : x[1], s[0] ? x[2] : x[0]};
   endfunction

   task automatic finish_test();
      $display("Checks %0d errors %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [31:0] tm, tv, an, e;
      logic [7:0]  v;
      void'($urandom(48));
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
      for (int a = 0; a < 16; a++) begin
         v = 8'($urandom);
         wr(a[3:0], v);
         rd(a[3:0], a == 2 ? v & 8'hF3 : a == 8 ? v & 8'h3F : a > 8 ? 8'h00 : v);
      end
      for (int k = 0; k < 8; k++) begin
         for (int a = 0; a < 8; a++) wr(a[3:0], {4{k[1:0]}});
         gpioOut   <= $urandom;
         gpioOe    <= $urandom;
         ptimerOut <= 4'($urandom);
         repeat (3) @(posedge clk_sys);
         #1;
         pins(k[1:0], ptimerOut, tm, tv, an);
         `CHK(padOe, (gpioOe & ~tm & ~an) | tm)
         `CHK(padOut & ~an, ((gpioOut & ~tm) | (tv & tm)) & ~an)
         `CHK(padAnalog, an)
         `CHK(analogChanEn, k[1:0] == 2'h3 ? 8'hFB : 8'h00)
         `CHK(specialFn, k[1:0] == 2'h3 ? 6'h2F : k[1:0] == 2'h2 ? 6'h10 : 6'h00)
      end
      for (int a = 0; a < 8; a++) wr(a[3:0], 8'h00);
      gpioOe <= 32'h0;
      for (int i = 0; i < 64; i++) begin
         wr(4'h8, i[7:0]);
         e = $urandom;
         extLevel <= e;
         auxPadIn <= 5'($urandom);
         repeat (10) @(posedge clk_sys);
         #1;
         `CHK(captureIn, cap(i[5:0], e, auxPadIn))
         `CHK({ptimer2ExtClock, ptimer1ExtClock}, {e[4], e[2]})
         `CHK(gpioIn, e)
      end
      finish_test();
   end

   initial begin
      #100000;
      errCount++;
      finish_test();
   end
endmodule

`default_nettype wire
